// ---- fim_pkg.sv ----
/*
 * Constants for the fault interrupt mask and soft reset block:
 * register offsets, field layout, reset values and pulse timing.
 * Assumes a single 10 MHz core clock.
 */
package fim_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int N_SRC  = 7;

  localparam logic [ADDR_W-1:0] ADDR_FAULT_FLAG = 8'h0a;
  localparam logic [ADDR_W-1:0] ADDR_FAULT_MASK = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_PART_INFO  = 8'h0d;

  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int SRC_FLD_MSB = 7;
  localparam int SRC_FLD_LSB = 1;
  localparam int RSVD_BIT    = 0;
  localparam int REG_RST_BIT = 7;
  localparam int PART_MSB    = 6;
  localparam int PART_LSB    = 3;
  localparam int REV_MSB     = 2;
  localparam int REV_LSB     = 0;

  // Source index inside the seven-bit source vector
  localparam int SRC_INOVP = 6;
  localparam int SRC_TSHD  = 5;
  localparam int SRC_BATOV = 4;
  localparam int SRC_FLYC  = 3;
  localparam int SRC_STMR  = 2;
  localparam int SRC_CAPPC = 1;
  localparam int SRC_WEAK  = 0;

  // ************************************************************
  // Reset values and codes
  // ************************************************************
  localparam logic [N_SRC-1:0]  MASK_RST   = 7'h00;
  localparam logic [N_SRC-1:0]  FLAG_RST   = 7'h00;
  localparam logic              RSVD_RD    = 1'h0;
  localparam logic [DATA_W-1:0] RDATA_NONE = 8'h00;
  // Arbitrary identification values
  localparam logic [3:0] PART_CODE_DEF = 4'h5;
  localparam logic [2:0] REV_CODE_DEF  = 3'h4;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int INT_PULSE_NS  = 500;
  localparam int INT_PULSE_CYC =
    (INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ---- fim_flag_if.sv ----
/*
 * Carrier between the top and the fault flag capture module.
 * Assumes both ends share one clock.
 */
`timescale 1ns/100ps

interface fim_flag_if #(
  parameter int N = 7
);
  logic         ce;
  logic         clr;
  logic [N-1:0] rise;
  logic [N-1:0] flags;

  modport src (input ce, input clr, output rise, output flags);
  modport snk (output ce, output clr, input rise, input flags);
endinterface

// ---- fim_flag_capture.sv ----
/*
 * Rising edge detection and sticky fault flags.
 * Assumes fault levels are synchronous to the core clock.
 */
`timescale 1ns/100ps

module fim_flag_capture #(
  parameter int N = 7
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [N-1:0] level_in,
  fim_flag_if.src           fl
);
  import fim_pkg::*;

  logic [N-1:0] level_r;
  logic [N-1:0] level_nxt;
  logic [N-1:0] flag_r;
  logic [N-1:0] flag_nxt;
  logic [N-1:0] rise_w;

  if (N < 1) begin : g_bad_n
    $error("fim_flag_capture needs at least one source");
  end

  // ************************************************************
  // Edge detect and flags
  // ************************************************************
  for (genvar i = 0; i < N; i++) begin : g_bit
    assign rise_w[i]   = level_in[i] & ~level_r[i];
    // Set wins over a clear in the same cycle
    assign flag_nxt[i] = rise_w[i] | (flag_r[i] & ~fl.clr);
  end

  always_comb begin
    level_nxt = level_in;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      level_r <= '0;
      flag_r  <= N'(FLAG_RST);
    end else if (fl.ce) begin
      level_r <= level_nxt;
      flag_r  <= flag_nxt;
    end
  end

  assign fl.rise  = rise_w;
  assign fl.flags = flag_r;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  chk_flag_clear: assert property (
    fl.ce && fl.clr && !(|rise_w) |=> flag_r == '0)
    else $error("fault flags not cleared");

  chk_flag_setwin: assert property (
    fl.ce && (|rise_w) |=> (flag_r & $past(rise_w)) == $past(rise_w))
    else $error("fault flag edge lost");

endmodule

// ---- fim_top.sv ----
/*
 * Fault interrupt mask, fault flag read-clear, part information and
 * software register reset, with the interrupt pulse generator.
 * Assumes a simple register port from the serial interface logic and
 * fault levels synchronous to CORE_CLK.
 */
`timescale 1ns/100ps

// How it works
// - Unmasked input overvoltage edge pulses the interrupt
// - Unmasked thermal shutdown edge pulses the interrupt
// - Unmasked battery overvoltage edge pulses the interrupt
// - Unmasked flying capacitor fault edge pulses interrupt
// - Unmasked safety timer expiry edge pulses interrupt
// - Unmasked cap precondition edge pulses the interrupt
// - Unmasked weak source edge pulses the interrupt
// - Mask bit zero always reads zero
// - Mask resets to zero, soft reset too
// - Register reset restores defaults, restarts safety timer
// - Writing zero to reset bit does nothing
// - Register reset bit clears itself when done
// - Part and revision codes are fixed read-only
// - Reading fault flags clears them all, except a flag whose source rises in the read cycle
module fim_top #(
  parameter int         PULSE_CYC = fim_pkg::INT_PULSE_CYC,
  parameter logic [3:0] PART_CODE = fim_pkg::PART_CODE_DEF,
  parameter logic [2:0] REV_CODE  = fim_pkg::REV_CODE_DEF
) (
  input  wire logic                        CORE_CLK,
  input  wire logic                        RESET,
  input  wire logic                        CE,
  input  wire logic                        INPUT_OVERVOLTAGE_EVENT,
  input  wire logic                        THERMAL_SHUTDOWN_EVENT,
  input  wire logic                        BATTERY_OVERVOLTAGE_EVENT,
  input  wire logic                        FLYING_CAP_FAULT_EVENT,
  input  wire logic                        SAFETY_TIMER_EXPIRED,
  input  wire logic                        CAP_PRECONDITION_FAULT_FLAG,
  input  wire logic                        WEAK_SOURCE_FAULT_FLAG,
  input  wire logic [fim_pkg::ADDR_W-1:0]  REG_ADDR,
  input  wire logic                        REG_WR,
  input  wire logic [fim_pkg::DATA_W-1:0]  REG_WDATA,
  input  wire logic                        REG_RD,
  output logic      [fim_pkg::DATA_W-1:0]  REG_RDATA,
  output logic                             INT_PULSE,
  output logic                             SAFETY_TIMER_RESTART
);
  import fim_pkg::*;

  localparam int CW      = $clog2(PULSE_CYC + 1);
  localparam int CHK_LAT = 2 * PULSE_CYC + 3;

  typedef enum logic [1:0] {
    FIM_IDLE  = 2'b00,
    FIM_PULSE = 2'b01,
    FIM_GAP   = 2'b10
  } fim_pulse_e;

  if (PULSE_CYC < 1) begin : g_bad_pulse
    $error("fim_top pulse length must be at least one cycle");
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] t);
    return a == t;
  endfunction

  // ************************************************************
  // Flag capture
  // ************************************************************
  logic [N_SRC-1:0] src_lvl;
  logic             rd_flag;
  logic             rst_busy_r;
  logic             rst_busy_nxt;

  fim_flag_if #(.N(N_SRC)) fl ();

  assign src_lvl = {INPUT_OVERVOLTAGE_EVENT, THERMAL_SHUTDOWN_EVENT,
                    BATTERY_OVERVOLTAGE_EVENT, FLYING_CAP_FAULT_EVENT,
                    SAFETY_TIMER_EXPIRED, CAP_PRECONDITION_FAULT_FLAG,
                    WEAK_SOURCE_FAULT_FLAG};
  assign rd_flag = REG_RD && hit(REG_ADDR, ADDR_FAULT_FLAG);
  assign fl.ce   = CE;
  assign fl.clr  = rd_flag || rst_busy_r;

  fim_flag_capture #(.N(N_SRC)) u_cap (
    .core_clk (CORE_CLK),
    .reset    (RESET),
    .level_in (src_lvl),
    .fl       (fl)
  );

  // ************************************************************
  // Register file
  // ************************************************************
  logic [N_SRC-1:0]  mask_r;
  logic [N_SRC-1:0]  mask_nxt;
  logic              restart_r;
  logic              restart_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  always_comb begin
    mask_nxt     = mask_r;
    rst_busy_nxt = rst_busy_r;
    restart_nxt  = 1'h0;
    rdata_nxt    = rdata_r;
    if (rst_busy_r) begin
      // Second step of the register reset, writes are not taken here
      mask_nxt     = MASK_RST;
      restart_nxt  = 1'h1;
      rst_busy_nxt = 1'h0;
    end else if (REG_WR) begin
      if (hit(REG_ADDR, ADDR_FAULT_MASK)) begin
        mask_nxt = REG_WDATA[SRC_FLD_MSB:SRC_FLD_LSB];
      end
      if (hit(REG_ADDR, ADDR_PART_INFO) && REG_WDATA[REG_RST_BIT]) begin
        rst_busy_nxt = 1'h1;
      end
    end
    if (REG_RD) begin
      if (hit(REG_ADDR, ADDR_FAULT_FLAG)) begin
        rdata_nxt = {fl.flags, RSVD_RD};
      end else if (hit(REG_ADDR, ADDR_FAULT_MASK)) begin
        rdata_nxt = {mask_r, RSVD_RD};
      end else if (hit(REG_ADDR, ADDR_PART_INFO)) begin
        rdata_nxt = {rst_busy_r, PART_CODE, REV_CODE};
      end else begin
        rdata_nxt = RDATA_NONE;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      mask_r     <= MASK_RST;
      rst_busy_r <= 1'h0;
      restart_r  <= 1'h0;
      rdata_r    <= RDATA_NONE;
    end else if (CE) begin
      mask_r     <= mask_nxt;
      rst_busy_r <= rst_busy_nxt;
      restart_r  <= restart_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  assign REG_RDATA            = rdata_r;
  assign SAFETY_TIMER_RESTART = restart_r;

  // ************************************************************
  // Interrupt pulse generator
  // ************************************************************
  fim_pulse_e    state_r;
  fim_pulse_e    state_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          pend_r;
  logic          pend_nxt;
  logic          int_r;
  logic          int_nxt;
  logic          evt;

  // Any number of sources rising together makes one event
  assign evt = |(fl.rise & ~mask_r);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    pend_nxt  = pend_r;
    unique case (state_r)
      FIM_IDLE: begin
        if (evt || pend_r) begin
          state_nxt = FIM_PULSE;
          cnt_nxt   = CW'(PULSE_CYC - 1);
          pend_nxt  = 1'h0;
        end
      end
      FIM_PULSE: begin
        // Events during a pulse are held and give one more pulse afterwards
        if (evt) begin
          pend_nxt = 1'h1;
        end
        if (cnt_r == '0) begin
          state_nxt = FIM_GAP;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      FIM_GAP: begin
        if (evt) begin
          pend_nxt = 1'h1;
        end
        state_nxt = FIM_IDLE;
      end
      default: begin
        state_nxt = FIM_IDLE;
      end
    endcase
    int_nxt = (state_nxt == FIM_PULSE);
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state_r <= FIM_IDLE;
      cnt_r   <= '0;
      pend_r  <= 1'h0;
      int_r   <= 1'h0;
    end else if (CE) begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      pend_r  <= pend_nxt;
      int_r   <= int_nxt;
    end
  end

  assign INT_PULSE = int_r;

  // ************************************************************
  // Checks
  // ************************************************************
  logic [CW:0] chk_hi_r;
  logic [CW:0] chk_hi_nxt;

  assign chk_hi_nxt = int_r ? (chk_hi_r + 1'b1) : '0;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      chk_hi_r <= '0;
    end else if (CE) begin
      chk_hi_r <= chk_hi_nxt;
    end
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET || !CE);

  sequence s_rst_step;
    rst_busy_r ##1 (!rst_busy_r && restart_r);
  endsequence

  sequence s_pulse_end;
    int_r ##1 !int_r;
  endsequence

  property p_fires(int k);
    fl.rise[k] && !mask_r[k] |-> ##[1:CHK_LAT] $rose(int_r);
  endproperty

  chk_inovp_irq: assert property (p_fires(SRC_INOVP))
    else $error("input overvoltage edge gave no pulse");
  chk_tshd_irq: assert property (p_fires(SRC_TSHD))
    else $error("thermal shutdown edge gave no pulse");
  chk_batov_irq: assert property (p_fires(SRC_BATOV))
    else $error("battery overvoltage edge gave no pulse");
  chk_flyc_irq: assert property (p_fires(SRC_FLYC))
    else $error("flying cap fault edge gave no pulse");
  chk_stmr_irq: assert property (p_fires(SRC_STMR))
    else $error("safety timer edge gave no pulse");
  chk_cappc_irq: assert property (p_fires(SRC_CAPPC))
    else $error("cap precondition edge gave no pulse");
  chk_weak_irq: assert property (p_fires(SRC_WEAK))
    else $error("weak source edge gave no pulse");

  chk_pulse_cause: assert property (
    $rose(int_r) |-> $past(evt) || $past(pend_r))
    else $error("interrupt pulse without unmasked event");

  chk_pulse_width: assert property (
    s_pulse_end |-> chk_hi_r == PULSE_CYC)
    else $error("interrupt pulse width wrong");

  chk_pulse_gap: assert property (
    s_pulse_end |=> !int_r)
    else $error("interrupt pulses not separated");

  chk_rsvd_zero: assert property (
    REG_RD && hit(REG_ADDR, ADDR_FAULT_MASK) |=> REG_RDATA[RSVD_BIT] == 1'h0)
    else $error("reserved mask bit read nonzero");

  chk_soft_mask: assert property (
    s_rst_step |-> mask_r == MASK_RST)
    else $error("register reset left mask set");

  chk_soft_timer: assert property (
    rst_busy_r |=> restart_r && !rst_busy_r)
    else $error("register reset did not restart timer");

  chk_no_restart: assert property (
    restart_r |-> $past(rst_busy_r))
    else $error("timer restart without register reset");

  chk_rst_selfclr: assert property (
    rst_busy_r |=> !rst_busy_r)
    else $error("register reset bit stuck");

  chk_id_fields: assert property (
    REG_RD && hit(REG_ADDR, ADDR_PART_INFO)
    |=> REG_RDATA[PART_MSB:REV_LSB] == {PART_CODE, REV_CODE})
    else $error("part information fields wrong");

endmodule

// ---- fim_host_model.sv ----
/*
 * Host model that drives the register port of the fault interrupt block,
 * one request per call, each held over exactly one rising edge.
 * Assumes the caller enters each request just after a rising edge.
 */
`timescale 1ns/100ps

module fim_host_model (
  input  wire logic                       core_clk,
  output logic                            reg_wr,
  output logic                            reg_rd,
  output logic [fim_pkg::ADDR_W-1:0]      reg_addr,
  output logic [fim_pkg::DATA_W-1:0]      reg_wdata
);
  import fim_pkg::*;

  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // *********************************************************************
  // Request task
  // *********************************************************************
  // Idle cycles invert address and data so stale values are never trusted
  task automatic bus(input logic w, input logic r,
                     input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_wr = w;
    reg_rd = r;
    if (!w && !r) begin
      reg_addr  = ~reg_addr;
      reg_wdata = ~reg_wdata;
    end else begin
      reg_addr  = a;
      reg_wdata = d;
    end
    @(posedge core_clk);
    #10;
  endtask
endmodule

// ---- fim_top_tb_top.sv ----
/*
 * Self-checking testbench for the fault interrupt mask block.
 * Assumes the host model in its own file and the design package.
 */
`timescale 1ns/100ps

module fim_top_tb_top;
  import fim_pkg::*;

  localparam int PC = 3;

  logic              CORE_CLK;
  logic              RESET;
  logic              CE;
  logic [6:0]        flt;
  wire logic         reg_wr;
  wire logic         reg_rd;
  wire logic [7:0]   reg_addr;
  wire logic [7:0]   reg_wdata;
  logic [7:0]        rdata;
  logic              irq;
  logic              tmr_rst;
  logic              rd_d;
  logic              irq_d;
  logic [7:0]        expq[$];
  logic [7:0]        pinfo;
  logic [7:0]        v;
  int                miscompares;
  int                checked;
  int                pulses;
  int                restarts;
  int                width;
  int                seed;
  int                p;

  assign pinfo = {1'b0, PART_CODE_DEF, REV_CODE_DEF};

  fim_top #(.PULSE_CYC(PC)) fim_top_i (
    .CORE_CLK                    (CORE_CLK),
    .RESET                       (RESET),
    .CE                          (CE),
    .INPUT_OVERVOLTAGE_EVENT     (flt[6]),
    .THERMAL_SHUTDOWN_EVENT      (flt[5]),
    .BATTERY_OVERVOLTAGE_EVENT   (flt[4]),
    .FLYING_CAP_FAULT_EVENT      (flt[3]),
    .SAFETY_TIMER_EXPIRED        (flt[2]),
    .CAP_PRECONDITION_FAULT_FLAG (flt[1]),
    .WEAK_SOURCE_FAULT_FLAG      (flt[0]),
    .REG_ADDR                    (reg_addr),
    .REG_WR                      (reg_wr),
    .REG_WDATA                   (reg_wdata),
    .REG_RD                      (reg_rd),
    .REG_RDATA                   (rdata),
    .INT_PULSE                   (irq),
    .SAFETY_TIMER_RESTART        (tmr_rst)
  );

  fim_host_model fim_host_model_i (
    .core_clk  (CORE_CLK),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata)
  );

  initial CORE_CLK = 1'b0;
  always #50 CORE_CLK = ~CORE_CLK;

  // *********************************************************************
  // Helpers
  // *********************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("Counts: checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    fim_host_model_i.bus(1'b0, 1'b1, a, 8'h00);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    fim_host_model_i.bus(1'b1, 1'b0, a, d);
  endtask

  task automatic idle(input int n);
    repeat (n) fim_host_model_i.bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask

  // *********************************************************************
  // Output monitor
  // *********************************************************************
  always @(posedge CORE_CLK) begin
    rd_d <= reg_rd & CE & !RESET;
  end

  always @(negedge CORE_CLK) begin
    if (rd_d === 1'b1) begin
      if (expq.size() == 0) begin
        miscompares++;
        $display("Error at %0t: unexpected read data %h", $time, rdata);
      end else begin
        chk(rdata, expq.pop_front());
      end
    end
    if (irq === 1'b1) width++;
    if (irq === 1'b1 && irq_d !== 1'b1) pulses++;
    if (irq !== 1'b1 && irq_d === 1'b1) begin
      chk(8'(width), 8'(PC));
      width = 0;
    end
    if (tmr_rst === 1'b1) restarts++;
    irq_d = irq;
  end

  initial begin
    #(100 * 20000);
    miscompares++;
    stop_test;
  end

  // *********************************************************************
  // Main sequence
  // *********************************************************************
  initial begin
    seed = 87;
    CE = 1'b1;
    RESET = 1'b1;
    flt = 7'h00;
    {miscompares, checked, pulses, restarts, width} = '0;
    repeat (6) @(posedge CORE_CLK);
    #10;
    RESET = 1'b0;
    rd(ADDR_FAULT_MASK, MASK_RST);
    rd(ADDR_PART_INFO, pinfo);
    rd(8'h0e, RDATA_NONE);
    repeat (4) begin
      v = 8'($random(seed));
      wr(ADDR_FAULT_MASK, v);
      rd(ADDR_FAULT_MASK, v & 8'hfe);
    end
    wr(ADDR_PART_INFO, 8'h7f);
    rd(ADDR_PART_INFO, pinfo);
    rd(ADDR_FAULT_MASK, v & 8'hfe);
    chk(8'(restarts), 8'h00);
    wr(ADDR_FAULT_MASK, 8'h00);
    // Clock enable low freezes the register port
    CE = 1'b0;
    wr(ADDR_FAULT_MASK, 8'hfe);
    CE = 1'b1;
    rd(ADDR_FAULT_MASK, 8'h00);
    for (int i = 0; i < 7; i++) begin
      p = pulses;
      flt[i] = 1'b1;
      idle(2 * PC + 3);
      flt[i] = 1'b0;
      idle(1);
      chk(8'(pulses - p), 8'h01);
      rd(ADDR_FAULT_FLAG, 8'(1 << (i + 1)));
      rd(ADDR_FAULT_FLAG, 8'h00);
      wr(ADDR_FAULT_MASK, 8'(1 << (i + 1)));
      flt[i] = 1'b1;
      idle(2 * PC + 3);
      flt[i] = 1'b0;
      wr(ADDR_FAULT_MASK, 8'h00);
      chk(8'(pulses - p), 8'h01);
      rd(ADDR_FAULT_FLAG, 8'(1 << (i + 1)));
    end
    // Several sources rising together
    p = pulses;
    flt = 7'h7f;
    idle(2 * PC + 3);
    flt = 7'h00;
    idle(1);
    chk(8'(pulses - p), 8'h01);
    rd(ADDR_FAULT_FLAG, 8'hfe);
    // Register reset with a pending flag and a set mask
    wr(ADDR_FAULT_MASK, 8'hfe);
    flt[0] = 1'b1;
    idle(2);
    flt[0] = 1'b0;
    p = restarts;
    wr(ADDR_PART_INFO, 8'h80);
    rd(ADDR_PART_INFO, pinfo | 8'h80);
    rd(ADDR_FAULT_MASK, 8'h00);
    rd(ADDR_PART_INFO, pinfo);
    rd(ADDR_FAULT_FLAG, 8'h00);
    idle(2);
    chk(8'(restarts - p), 8'h01);
    // Second reset in mid-run
    wr(ADDR_FAULT_MASK, 8'h5a);
    RESET = 1'b1;
    idle(2);
    RESET = 1'b0;
    rd(ADDR_FAULT_MASK, 8'h00);
    idle(3);
    chk(8'(expq.size()), 8'h00);
    stop_test;
  end
endmodule
